// *** hw/tcov_pkg.sv ***
`default_nettype none
package tcov_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_COUNT  = 8'h04;
  localparam logic [7:0] ADDR_LIM_HI = 8'h08;
  localparam logic [7:0] ADDR_LIM_LO = 8'h0C;
  localparam logic [7:0] ADDR_EVT    = 8'h10;
  localparam logic [7:0] ADDR_MASK   = 8'h14;
  localparam logic [7:0] ADDR_CMP    = 8'h18;

  // control word field positions
  localparam int CTRL_PIN_EN_BIT = 8;
  localparam int CTRL_FLAG_BIT   = 7;

  // event status bit positions
  localparam int EVT_WRAP   = 0;
  localparam int EVT_CENTER = 1;
  localparam int EVT_MATCH  = 2;
  localparam int EVT_W      = 3;

  // reset and boundary values
  localparam logic [15:0] CNT_RESET   = 16'h0000;
  localparam logic [15:0] CNT_MAX     = 16'hFFFF;
  localparam logic [15:0] CMP_RESET   = 16'h0000;
  localparam logic [7:0]  LIMIT_RESET = 8'h00;
  localparam logic [2:0]  PRE_RESET   = 3'h0;
  localparam int          SYNC_STAGES = 2;

  // counting source to the prescaler
  typedef enum logic [1:0] {
    TCOV_SRC_STOP  = 2'b00,
    TCOV_SRC_BUS   = 2'b01,
    TCOV_SRC_FIXED = 2'b10,
    TCOV_SRC_EXT   = 2'b11
  } tcov_src_t;

  // counting direction in center-aligned mode
  typedef enum logic {
    TCOV_DIR_UP   = 1'b0,
    TCOV_DIR_DOWN = 1'b1
  } tcov_dir_t;

  // control and status word
  typedef struct packed {
    logic      pin_en;
    logic      wrap_flag;
    logic      wrap_irq_enable;
    logic      center_aligned_select;
    tcov_src_t count_source_select;
    logic [2:0] prescale;
  } tcov_ctrl_t;

  localparam tcov_ctrl_t CTRL_RESET = '{1'b0, 1'b0, 1'b0, 1'b0, TCOV_SRC_STOP, 3'h0};

endpackage
`default_nettype wire

// *** hw/tcov_edge_sync.sv ***
`default_nettype none
module tcov_edge_sync
  import tcov_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic async_i,
  output logic      rise_o
);

  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  // two-stage synchroniser, then a delay stage for edge detection
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // one-cycle pulse per rising edge of the synchronised input
  assign rise_o = sync_reg & ~prev_reg;

endmodule // tcov_edge_sync
`default_nettype wire

// *** hw/tcov_timer.sv ***
// Overview of operation
// RULE1 - 16-bit main counter with readable wrap flag reporting overflow.
// RULE2 - interrupt level asserted while wrap flag set and wrap interrupt enabled.
// RULE3 - free run edge-aligned: 0xFFFF wraps to 0x0000, flag sets there.
// RULE4 - nonzero limit, edge-aligned: limit returns to 0x0000, flag sets there.
// RULE5 - center mode reverses at limit; flag sets stepping down; zero is center.
// RULE6 - writing one limit byte suppresses flag until the other is written.
// RULE7 - reset clears limit to zero; zero limit means full range count.
// RULE8 - debug mode halts counter and freezes read coherency latches.
// RULE9 - software must not use input capture on the external clock pin.
// RULE10 - channel still does output compare with external clock, pin untouched.
// RULE11 - software writes both limit bytes soon after overflow or resets counter.
// RULE12 - source select: 00 stop, 01 bus, 10 fixed clock, 11 external pin.
// RULE13 - external clock synchronised by bus clock; must be under quarter rate.
// RULE14 - flag cleared by status read while set, then writing zero; set wins.
// RULE15 - no counting while source is zero; one step per prescaled edge.
//
// Added by the designer: the address map and the Wishbone slave port.
`default_nettype none
module tcov_timer
  import tcov_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        ext_clk_i,
  input  wire logic        fixed_clk_i,
  input  wire logic        dbg_active_i,
  output logic             chan_out_o,
  output logic             chan_oe_o,
  output logic             irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  tcov_ctrl_t        ctrl_reg;
  logic [15:0]       cnt_reg;
  logic [15:0]       cnt_next;
  tcov_dir_t         dir_reg;
  tcov_dir_t         dir_next;
  logic [7:0]        lim_hi_reg;
  logic [7:0]        lim_lo_reg;
  logic [1:0]        lim_pend_reg;
  logic [15:0]       cmp_reg;
  logic [2:0]        pre_cnt_reg;
  logic [EVT_W-1:0]  evt_reg;
  logic [EVT_W-1:0]  mask_reg;
  logic              flag_arm_reg;
  logic [15:0]       latch_reg;
  logic              latch_valid_reg;
  logic              latch_hi_first_reg;
  logic              chan_out_reg;
  logic              ack_reg;
  logic [31:0]       rdata_reg;
  logic              ext_rise;
  logic              fixed_rise;
  logic              src_tick;
  logic              count_step;
  logic [2:0]        pre_mask;
  logic [15:0]       top_val;
  logic              wrap_evt;
  logic              center_evt;
  logic              match_evt;
  logic              access;
  logic              wr;
  logic              rd;
  logic [15:0]       cnt_view;

  // true when the bus addresses the given register
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] base);
    hit = (adr == base);
  endfunction

  assign access = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wr     = access & wb_we_i;
  assign rd     = access & ~wb_we_i;

  ////////////////////////////////////////////////////////////////////////////
  // counting source and prescaler

  // pin clocks pass a synchroniser on the bus clock
  tcov_edge_sync u_ext_sync (  // [RULE13]
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (ext_clk_i),
    .rise_o  (ext_rise)
  );

  tcov_edge_sync u_fixed_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (fixed_clk_i),
    .rise_o  (fixed_rise)
  );

  // source select feeds the prescaler input
  always_comb
  begin
    case (ctrl_reg.count_source_select)  // [RULE12]
      TCOV_SRC_BUS:   src_tick = 1'b1;
      TCOV_SRC_FIXED: src_tick = fixed_rise;
      TCOV_SRC_EXT:   src_tick = ext_rise;
      default:        src_tick = 1'b0;  // stopped [RULE15]
    endcase
  end

  // divide by two to the power of prescale; prescale values above 3 divide by eight
  assign pre_mask   = 3'(~(3'h7 << ctrl_reg.prescale));
  assign count_step = src_tick & ~dbg_active_i
                      & ((pre_cnt_reg & pre_mask) == pre_mask);  // [RULE15] [RULE8]

  // prescaler counter, cleared with the main counter
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pre_cnt_reg <= PRE_RESET;
    else if (wr && hit(wb_adr_i, ADDR_COUNT))
      pre_cnt_reg <= PRE_RESET;
    else if (src_tick && !dbg_active_i)
      pre_cnt_reg <= pre_cnt_reg + 3'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // main counter

  // zero limit means full range
  assign top_val = ({lim_hi_reg, lim_lo_reg} == 16'h0000) ? CNT_MAX
                   : {lim_hi_reg, lim_lo_reg};  // [RULE7]

  // next count, direction and period events
  always_comb
  begin
    cnt_next   = cnt_reg;
    dir_next   = dir_reg;
    wrap_evt   = 1'b0;
    center_evt = 1'b0;
    if (!ctrl_reg.center_aligned_select)
    begin
      dir_next = TCOV_DIR_UP;
      if (cnt_reg == top_val)
      begin
        cnt_next = CNT_RESET;  // [RULE3] [RULE4]
        wrap_evt = 1'b1;
      end
      else
        cnt_next = cnt_reg + 16'h0001;
    end
    else if (dir_reg == TCOV_DIR_UP)
    begin
      if (cnt_reg == top_val)
      begin
        cnt_next = cnt_reg - 16'h0001;  // reverse at limit [RULE5]
        dir_next = TCOV_DIR_DOWN;
        wrap_evt = 1'b1;
      end
      else
        cnt_next = cnt_reg + 16'h0001;
    end
    else
    begin
      if (cnt_reg == CNT_RESET)
      begin
        cnt_next   = 16'h0001;  // period center
        dir_next   = TCOV_DIR_UP;
        center_evt = 1'b1;
      end
      else
        cnt_next = cnt_reg - 16'h0001;
    end
  end

  // counter register; a write to the count register restarts it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_reg <= CNT_RESET;
      dir_reg <= TCOV_DIR_UP;
    end
    else if (wr && hit(wb_adr_i, ADDR_COUNT))
    begin
      cnt_reg <= CNT_RESET;
      dir_reg <= TCOV_DIR_UP;
    end
    else if (count_step)
    begin
      cnt_reg <= cnt_next;  // [RULE1]
      dir_reg <= dir_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // limit registers and write pairing

  // limit bytes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lim_hi_reg <= LIMIT_RESET;  // [RULE7]
      lim_lo_reg <= LIMIT_RESET;
    end
    else if (wr && wb_sel_i[0])
    begin
      if (hit(wb_adr_i, ADDR_LIM_HI))
        lim_hi_reg <= wb_dat_i[7:0];
      else if (hit(wb_adr_i, ADDR_LIM_LO))
        lim_lo_reg <= wb_dat_i[7:0];
    end
  end

  // bit1: high written awaiting low, bit0: low written awaiting high
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      lim_pend_reg <= 2'h0;
    else if (wr && wb_sel_i[0])
    begin
      if (hit(wb_adr_i, ADDR_LIM_HI))
        lim_pend_reg <= lim_pend_reg[0] ? 2'h0 : 2'h2;  // [RULE6]
      else if (hit(wb_adr_i, ADDR_LIM_LO))
        lim_pend_reg <= lim_pend_reg[1] ? 2'h0 : 2'h1;  // [RULE6]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register and wrap flag

  // software control fields and wrap flag, one process for the whole word
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_reg <= CTRL_RESET;
    else
    begin
      if (wr && hit(wb_adr_i, ADDR_CTRL))
      begin
        if (wb_sel_i[1])
          ctrl_reg.pin_en <= wb_dat_i[CTRL_PIN_EN_BIT];
        if (wb_sel_i[0])
        begin
          ctrl_reg.wrap_irq_enable       <= wb_dat_i[6];
          ctrl_reg.center_aligned_select <= wb_dat_i[5];
          ctrl_reg.count_source_select   <= tcov_src_t'(wb_dat_i[4:3]);
          ctrl_reg.prescale              <= wb_dat_i[2:0];
        end
      end
      // wrap flag: set beats clear; a limit pair in progress masks the wrap
      if (count_step && wrap_evt && (lim_pend_reg == 2'h0))
        ctrl_reg.wrap_flag <= 1'b1;  // [RULE3] [RULE4] [RULE5] [RULE6] [RULE14]
      else if (wr && hit(wb_adr_i, ADDR_CTRL) && wb_sel_i[0] && flag_arm_reg
               && !wb_dat_i[CTRL_FLAG_BIT])
        ctrl_reg.wrap_flag <= 1'b0;  // [RULE14]
    end
  end

  // reading the control word with the flag set arms the clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      flag_arm_reg <= 1'b0;
    else if (wr && hit(wb_adr_i, ADDR_CTRL))
      flag_arm_reg <= 1'b0;
    else if (rd && hit(wb_adr_i, ADDR_CTRL) && ctrl_reg.wrap_flag)
      flag_arm_reg <= 1'b1;  // [RULE14]
  end

  // compare match on a counting step at the current value
  assign match_evt = count_step & (cnt_reg == cmp_reg);

  ////////////////////////////////////////////////////////////////////////////
  // event status, mask and compare channel

  // sticky events, write one to clear, set wins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      evt_reg <= '0;
    else
      evt_reg <= (evt_reg & ~((wr && hit(wb_adr_i, ADDR_EVT) && wb_sel_i[0])
                              ? wb_dat_i[EVT_W-1:0] : {EVT_W{1'b0}}))
                 | {match_evt,
                    count_step & center_evt,
                    count_step & wrap_evt & (lim_pend_reg == 2'h0)};  // [RULE6]
  end

  // mask and compare value
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mask_reg <= '0;
      cmp_reg  <= CMP_RESET;
    end
    else if (wr)
    begin
      if (hit(wb_adr_i, ADDR_MASK) && wb_sel_i[0])
        mask_reg <= wb_dat_i[EVT_W-1:0];
      else if (hit(wb_adr_i, ADDR_CMP))
      begin
        if (wb_sel_i[0])
          cmp_reg[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1])
          cmp_reg[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // output compare toggles the channel whatever the source
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      chan_out_reg <= 1'b0;
    else if (match_evt)
      chan_out_reg <= ~chan_out_reg;  // [RULE10]
  end

  assign chan_out_o = chan_out_reg;
  // pin stays undriven while it supplies the external clock
  assign chan_oe_o  = ctrl_reg.pin_en
                      & (ctrl_reg.count_source_select != TCOV_SRC_EXT);  // [RULE10] [RULE9]

  // interrupt level
  assign irq_o = (ctrl_reg.wrap_flag & ctrl_reg.wrap_irq_enable)  // [RULE2]
                 | (|(evt_reg & mask_reg));

  ////////////////////////////////////////////////////////////////////////////
  // counter read coherency

  // single-byte reads latch the other byte until it is read
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      latch_reg          <= CNT_RESET;
      latch_valid_reg    <= 1'b0;
      latch_hi_first_reg <= 1'b0;
    end
    else if (rd && hit(wb_adr_i, ADDR_COUNT) && !dbg_active_i)  // frozen in debug [RULE8]
    begin
      if (wb_sel_i[1:0] == 2'b11)
        latch_valid_reg <= 1'b0;
      else if (wb_sel_i[1] != wb_sel_i[0])
      begin
        if (!latch_valid_reg)
        begin
          latch_reg          <= cnt_reg;
          latch_valid_reg    <= 1'b1;
          latch_hi_first_reg <= wb_sel_i[1];
        end
        else if (latch_hi_first_reg != wb_sel_i[1])
          latch_valid_reg <= 1'b0;
      end
    end
  end

  assign cnt_view = latch_valid_reg ? latch_reg : cnt_reg;

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave

  // one-cycle acknowledge, dropped in the following cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_reg <= 1'b0;
    else
      ack_reg <= wb_cyc_i & wb_stb_i & ~ack_reg;
  end

  // read data captured with the access; unmapped reads return zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdata_reg <= 32'h0000_0000;
    else if (rd)
    begin
      if (hit(wb_adr_i, ADDR_CTRL))
        rdata_reg <= {23'h000000, ctrl_reg};  // [RULE1]
      else if (hit(wb_adr_i, ADDR_COUNT))
        rdata_reg <= {16'h0000, cnt_view};
      else if (hit(wb_adr_i, ADDR_LIM_HI))
        rdata_reg <= {24'h000000, lim_hi_reg};
      else if (hit(wb_adr_i, ADDR_LIM_LO))
        rdata_reg <= {24'h000000, lim_lo_reg};
      else if (hit(wb_adr_i, ADDR_EVT))
        rdata_reg <= {29'h00000000, evt_reg};
      else if (hit(wb_adr_i, ADDR_MASK))
        rdata_reg <= {29'h00000000, mask_reg};
      else if (hit(wb_adr_i, ADDR_CMP))
        rdata_reg <= {16'h0000, cmp_reg};
      else
        rdata_reg <= 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

endmodule // tcov_timer
`default_nettype wire

// *** sim/tcov_timer_assertions.sv ***
`default_nettype none
module tcov_timer_assertions
  import tcov_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        ext_clk_i,
  input wire logic        fixed_clk_i,
  input wire logic        dbg_active_i,
  input wire logic        chan_out_o,
  input wire logic        chan_oe_o,
  input wire logic        irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////
  // bus handshake steps
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ans;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  property p_ack_resp;
    s_req |=> s_ans;
  endproperty
  property p_ack_cause;
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  property p_idle;
    !wb_cyc_i |=> !wb_ack_o;
  endproperty
  property p_dat_hold;
    !wb_ack_o |-> $stable(wb_dat_o);
  endproperty
  property p_rst_irq;
    $fell(rst_i) |-> !irq_o && !wb_ack_o;
  endproperty
  property p_rst_out;
    $fell(rst_i) |-> !chan_out_o && !chan_oe_o && wb_dat_o == 32'h0;
  endproperty
  property p_dbg_chan;
    dbg_active_i |=> $stable(chan_out_o);
  endproperty
  property p_dbg_irq;
    dbg_active_i && !irq_o && !wb_cyc_i |=> !irq_o;
  endproperty
  ////////////////////////////////////////////////////////////
  a_ack_resp: assert property (p_ack_resp) else $error("no single ack");
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  a_idle: assert property (p_idle) else $error("ack while idle");
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
  a_rst_irq: assert property (p_rst_irq) else $error("irq after reset");
  a_rst_out: assert property (p_rst_out) else $error("outputs not cleared");
  a_dbg_chan: assert property (p_dbg_chan) else $error("channel moved in debug");
  a_dbg_irq: assert property (p_dbg_irq) else $error("irq rose in debug");
endmodule // tcov_timer_assertions
`default_nettype wire

// *** sim/tcov_timer_tb.sv ***
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; $display("[ERR] %0t got %h", $time, (a)); end end
module tcov_timer_tb
  import tcov_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic we; logic [7:0] a; logic [31:0] d; logic [31:0] e;} tcov_row_t;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic        ext_clk_i, fixed_clk_i, dbg_active_i, chan_out_o, chan_oe_o, irq_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q, v;
  int          n_fail, checks;
  tcov_row_t   rows [10];
  tcov_timer tcov_timer_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .ext_clk_i(ext_clk_i), .fixed_clk_i(fixed_clk_i), .dbg_active_i(dbg_active_i),
    .chan_out_o(chan_out_o), .chan_oe_o(chan_oe_o), .irq_o(irq_o));
  ////////////////////////////////////////////////////////////
  // one classic cycle, read data into q
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  // wait for irq under a bound
  task automatic wirq(input int n);
    for (int i = 0; i < n && irq_o !== 1'b1; i++) @(posedge clk_i);
  endtask
  // stop counting and clear the flag
  task clr;
    wb(1'b1, ADDR_CTRL, 32'h0);
    wb(1'b0, ADDR_CTRL, 32'h0);
    wb(1'b1, ADDR_CTRL, 32'h0);
  endtask
  // one slow pin pulse, eight bus clocks a period
  task pulse(input logic e);
    repeat (4) @(posedge clk_i);
    if (e) ext_clk_i <= 1'b1;
    else fixed_clk_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    {ext_clk_i, fixed_clk_i} <= 2'b00;
  endtask
  task stop_test;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // clock
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // watchdog
  initial
  begin
    #1800000;
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    stop_test();
  end
  // main sequence
  initial
  begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, ext_clk_i, fixed_clk_i, dbg_active_i} = 7'b1000000;
    {wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    wb_sel_i = 4'h3;
    n_fail = 0;
    checks = 0;
    rows = '{'{0, ADDR_CTRL, 0, 0}, '{0, ADDR_LIM_HI, 0, 0}, '{0, ADDR_LIM_LO, 0, 0}, '{0, ADDR_COUNT, 0, 0},
      '{1, ADDR_MASK, 7, 0}, '{0, ADDR_MASK, 0, 7}, '{1, ADDR_MASK, 0, 0}, '{1, ADDR_CMP, 32'h1234, 0},
      '{0, ADDR_CMP, 0, 32'h1234}, '{0, 8'hFC, 0, 0}};
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i])
    begin
      wb(rows[i].we, rows[i].a, rows[i].d);
      if (!rows[i].we) `CHK(q, rows[i].e)
    end
    $display("register table done");
    wb(1'b1, ADDR_COUNT, 32'h0);
    wb(1'b1, ADDR_CTRL, 32'h48);
    repeat (65500) @(posedge clk_i);
    `CHK(irq_o, 1'b0)
    wirq(100);
    `CHK(irq_o, 1'b1)
    // write before any status read: flag stays, enable off hides it
    wb(1'b1, ADDR_CTRL, 32'h0);
    `CHK(irq_o, 1'b0)
    wb(1'b0, ADDR_CTRL, 32'h0);
    `CHK(q[7], 1'b1)
    $display("free run done");
    // armed by the read: write zero clears, enable on shows it
    wb(1'b1, ADDR_CTRL, 32'h40);
    `CHK(irq_o, 1'b0)
    wb(1'b0, ADDR_CTRL, 32'h0);
    `CHK(q[7], 1'b0)
    wb(1'b1, ADDR_MASK, 32'h1);
    `CHK(irq_o, 1'b1)
    wb(1'b1, ADDR_EVT, 32'h1);
    `CHK(irq_o, 1'b0)
    wb(1'b1, ADDR_MASK, 32'h0);
    $display("flag clear done");
    wb(1'b1, ADDR_COUNT, 32'h0);
    wb(1'b1, ADDR_LIM_HI, 32'h0);
    wb(1'b1, ADDR_LIM_LO, 32'h0F);
    wb(1'b1, ADDR_CTRL, 32'h48);
    wirq(40);
    `CHK(irq_o, 1'b1)
    wb(1'b0, ADDR_COUNT, 32'h0);
    `CHK(q[15:0] <= 16'h000F, 1'b1)
    $display("limit done");
    clr();
    wb(1'b1, ADDR_COUNT, 32'h0);
    wb(1'b1, ADDR_LIM_HI, 32'h0);
    wb(1'b1, ADDR_CTRL, 32'h48);
    repeat (60) @(posedge clk_i);
    `CHK(irq_o, 1'b0)
    wb(1'b1, ADDR_LIM_LO, 32'h0F);
    wirq(40);
    `CHK(irq_o, 1'b1)
    $display("limit pairing done");
    clr();
    wb(1'b1, ADDR_COUNT, 32'h0);
    wb(1'b1, ADDR_CTRL, 32'h68);
    wirq(60);
    `CHK(irq_o, 1'b1)
    wb(1'b0, ADDR_COUNT, 32'h0);
    `CHK(q[15:0] >= 16'h0008 && q[15:0] < 16'h000F, 1'b1)
    $display("center done");
    clr();
    wb(1'b1, ADDR_LIM_LO, 32'h0);
    wb(1'b1, ADDR_LIM_HI, 32'h0);
    wb(1'b1, ADDR_CMP, 32'h2);
    for (int s = 0; s < 2; s++)
    begin
      wb(1'b1, ADDR_COUNT, 32'h0);
      v[0] = chan_out_o;
      // clock pin used for output compare only, never for capture
      wb(1'b1, ADDR_CTRL, s ? 32'h118 : 32'h110);
      `CHK(chan_oe_o, s ? 1'b0 : 1'b1)
      repeat (5) pulse(1'b1);
      repeat (3) pulse(1'b0);
      repeat (8) @(posedge clk_i);
      wb(1'b1, ADDR_CTRL, 32'h0);
      wb(1'b0, ADDR_COUNT, 32'h0);
      `CHK(q[15:0], s ? 16'h0005 : 16'h0003)
      `CHK(chan_out_o, ~v[0])
    end
    $display("sources done");
    wb(1'b1, ADDR_CTRL, 32'h08);
    @(posedge clk_i);
    dbg_active_i <= 1'b1;
    wb(1'b0, ADDR_COUNT, 32'h0);
    v = q;
    repeat (5) @(posedge clk_i);
    wb(1'b0, ADDR_COUNT, 32'h0);
    `CHK(q, v)
    dbg_active_i <= 1'b0;
    wb(1'b0, ADDR_COUNT, 32'h0);
    `CHK(q !== v, 1'b1)
    // low byte read latches; a high byte read in debug must not free it
    wb_sel_i <= 4'h1;
    wb(1'b0, ADDR_COUNT, 32'h0);
    v = q;
    dbg_active_i <= 1'b1;
    wb_sel_i <= 4'h2;
    wb(1'b0, ADDR_COUNT, 32'h0);
    `CHK(q, v)
    dbg_active_i <= 1'b0;
    wb_sel_i <= 4'h3;
    repeat (3) @(posedge clk_i);
    wb(1'b0, ADDR_COUNT, 32'h0);
    `CHK(q, v)
    $display("debug done");
    // reset in mid-run clears limit, count and outputs
    wb(1'b1, ADDR_LIM_HI, 32'hAB);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    `CHK({chan_out_o, irq_o}, 2'b00)
    wb(1'b0, ADDR_LIM_HI, 32'h0);
    `CHK(q, 32'h0)
    wb(1'b0, ADDR_COUNT, 32'h0);
    `CHK(q, 32'h0)
    $display("reset done");
    stop_test();
  end
endmodule // tcov_timer_tb
bind tcov_timer tcov_timer_assertions tcov_timer_assertions_inst (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_clk_i(ext_clk_i),
  .fixed_clk_i(fixed_clk_i), .dbg_active_i(dbg_active_i), .chan_out_o(chan_out_o),
  .chan_oe_o(chan_oe_o), .irq_o(irq_o));
`default_nettype wire
